// ---- inc/sbx_pkg.sv ----
// Package: opcodes, flag positions, cycle counts and register map for the store/bit/flag unit
package sbx_pkg;
  // ==========================================================================
  // Operations
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ST = 5'h01, OP_ST_INC = 5'h02, OP_ST_DEC = 5'h03, OP_ST_DISP = 5'h04,
    OP_PM_LOAD = 5'h05, OP_PM_LOAD_INC = 5'h06, OP_PM_STORE = 5'h07, OP_PUSH = 5'h08,
    OP_POP = 5'h09, OP_IO_SET = 5'h0A, OP_IO_CLR = 5'h0B, OP_ROT_UP = 5'h0C,
    OP_ROT_DOWN = 5'h0D, OP_T_STORE = 5'h0E, OP_T_LOAD = 5'h0F, OP_FLAG_SET = 5'h10,
    OP_FLAG_CLR = 5'h11, OP_SLEEP = 5'h12, OP_WDOG = 5'h13, OP_BREAK = 5'h14
  } sbx_op_type;
  // ==========================================================================
  // Flag word bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] STACK_RST = 16'h04FF;
  localparam logic [7:0] IO_BIT_LIMIT = 8'h1F;
  // ==========================================================================
  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'd1;
  localparam logic [1:0] CYC_TWO = 2'd2;
  localparam logic [1:0] CYC_THREE = 2'd3;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_OPND = 8'h04;
  localparam logic [7:0] ADR_PTRX = 8'h08;
  localparam logic [7:0] ADR_PTRY = 8'h0C;
  localparam logic [7:0] ADR_PTRZ = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  localparam logic [7:0] ADR_REG = 8'h18;
  localparam logic [7:0] ADR_SP = 8'h1C;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  // ==========================================================================
  // Memory request carried to data, program and I/O space
  typedef struct packed {
    logic data_we;
    logic prog_re;
    logic prog_we;
    logic io_we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sbx_mem_type;
endpackage

// ---- logic/sbx_exec.sv ----
// Execution unit for indirect stores, program memory, stack, bit and flag operations
// Operation
// - Post-increment store writes then bumps pointer, two cycles
// - Pre-decrement store decrements pointer first, two cycles
// - Displaced store uses pointer plus offset, two cycles
// - Program load via third pointer, three cycles
// - Push and pop take two cycles
// - I/O bit set forces one, two cycles
// - I/O bit clear forces zero, two cycles
// - Rotate up through carry, flags one cycle
// - Rotate down through carry, flags one cycle
// - Transfer-bit store copies register bit to flag
// - Transfer-bit load copies flag into register bit
// - Single flag set or clear, one cycle
// - Sign flag raise/clear alters only sign
// - Nop, sleep, watchdog kick take one cycle
// - Break only acts for debug, no flags
// - I/O bit ops reach addresses 0x00 to 0x1F
`timescale 1ns/1ps
module sbx_exec (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [7:0] MEM_RDATA_I,
  output sbx_pkg::sbx_mem_type MEM_REQ_O,
  output logic SLEEP_REQ_O,
  output logic WDOG_KICK_O,
  output logic DEBUG_BREAK_O,
  input wire logic DEBUG_EN_I
);
  // ==========================================================================
  // State
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACC = 2'b01, ST_FIN = 2'b11} sbx_state_type;
  sbx_state_type state_ff, nxt_state;
  logic [1:0] cnt_ff, nxt_cnt;
  sbx_pkg::sbx_op_type op_ff, nxt_op;
  logic [7:0] flag_word_ff, nxt_flag_word;
  logic [15:0] ptr_ff [3];
  logic [15:0] nxt_ptr [3];
  logic [15:0] sp_ff, nxt_sp;
  logic [7:0] reg_ff, nxt_reg;
  logic [15:0] wpair_ff, nxt_wpair;
  logic [1:0] sel_ff, nxt_sel;
  logic [5:0] disp_ff, nxt_disp;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] io_ff, nxt_io;
  logic busy_ff, nxt_busy;
  logic err_ff, nxt_err;
  sbx_pkg::sbx_mem_type mem_ff, nxt_mem;
  logic sleep_ff, nxt_sleep, wdog_ff, nxt_wdog, brk_ff, nxt_brk;
  // AXI state
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic wr_fire;

  // Cycle count of each operation
  function automatic logic [1:0] op_cycles(input sbx_pkg::sbx_op_type op);
    case (op)
      sbx_pkg::OP_ST, sbx_pkg::OP_ST_INC, sbx_pkg::OP_ST_DEC, sbx_pkg::OP_ST_DISP,
      sbx_pkg::OP_PUSH, sbx_pkg::OP_POP, sbx_pkg::OP_IO_SET,
      sbx_pkg::OP_IO_CLR: op_cycles = sbx_pkg::CYC_TWO;
      sbx_pkg::OP_PM_LOAD, sbx_pkg::OP_PM_LOAD_INC,
      sbx_pkg::OP_PM_STORE: op_cycles = sbx_pkg::CYC_THREE;
      default: op_cycles = sbx_pkg::CYC_ONE;
    endcase
  endfunction

  // ==========================================================================
  // AXI4-Lite slave: one write and one read in flight
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_bv = bv_ff;
    nxt_bresp = bresp_ff;
    nxt_rv = rv_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (S_AXI_AWVALID_I && !aw_ff && !bv_ff) begin
      nxt_aw = 1'b1;
      nxt_awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !w_ff && !bv_ff) begin
      nxt_w = 1'b1;
      nxt_wdata = S_AXI_WDATA_I;
    end
    if (wr_fire) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_bresp = sbx_pkg::RESP_OK;
      if (awaddr_ff != sbx_pkg::ADR_CMD && awaddr_ff != sbx_pkg::ADR_OPND
          && awaddr_ff != sbx_pkg::ADR_PTRX && awaddr_ff != sbx_pkg::ADR_PTRY
          && awaddr_ff != sbx_pkg::ADR_PTRZ && awaddr_ff != sbx_pkg::ADR_REG
          && awaddr_ff != sbx_pkg::ADR_SP && awaddr_ff != sbx_pkg::ADR_STAT) begin
        nxt_bresp = sbx_pkg::RESP_ERR;
      end
    end
    if (bv_ff && S_AXI_BREADY_I) begin
      nxt_bv = 1'b0;
    end
    if (S_AXI_ARVALID_I && !rv_ff) begin
      nxt_rv = 1'b1;
      nxt_rresp = sbx_pkg::RESP_OK;
      if (S_AXI_ARADDR_I == sbx_pkg::ADR_PTRX) begin
        nxt_rdata = {16'h0000, ptr_ff[0]};
      end else if (S_AXI_ARADDR_I == sbx_pkg::ADR_PTRY) begin
        nxt_rdata = {16'h0000, ptr_ff[1]};
      end else if (S_AXI_ARADDR_I == sbx_pkg::ADR_PTRZ) begin
        nxt_rdata = {16'h0000, ptr_ff[2]};
      end else if (S_AXI_ARADDR_I == sbx_pkg::ADR_STAT) begin
        nxt_rdata = {22'h00_0000, err_ff, busy_ff, flag_word_ff};
      end else if (S_AXI_ARADDR_I == sbx_pkg::ADR_REG) begin
        nxt_rdata = {24'h00_0000, reg_ff};
      end else if (S_AXI_ARADDR_I == sbx_pkg::ADR_SP) begin
        nxt_rdata = {16'h0000, sp_ff};
      end else if (S_AXI_ARADDR_I == sbx_pkg::ADR_CMD || S_AXI_ARADDR_I == sbx_pkg::ADR_OPND) begin
        nxt_rdata = 32'h0000_0000;
      end else begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = sbx_pkg::RESP_ERR;
      end
    end else if (rv_ff && S_AXI_RREADY_I) begin
      nxt_rv = 1'b0;
    end
  end

  // Write completes once both address and data are held
  assign wr_fire = aw_ff && w_ff && !bv_ff;

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      bv_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rv_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'b00;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      bv_ff <= nxt_bv;
      bresp_ff <= nxt_bresp;
      rv_ff <= nxt_rv;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ==========================================================================
  // Execution sequencer
  always_comb begin
    logic [1:0] ps;
    logic [15:0] pv;
    logic [7:0] res;
    ps = sel_ff;
    pv = (sel_ff == 2'd3) ? ptr_ff[2] : ptr_ff[sel_ff];
    res = reg_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    nxt_flag_word = flag_word_ff;
    nxt_ptr = ptr_ff;
    nxt_sp = sp_ff;
    nxt_reg = reg_ff;
    nxt_wpair = wpair_ff;
    nxt_sel = sel_ff;
    nxt_disp = disp_ff;
    nxt_bit = bit_ff;
    nxt_io = io_ff;
    nxt_busy = busy_ff;
    nxt_err = err_ff;
    nxt_mem = '0;
    nxt_sleep = 1'b0;
    nxt_wdog = 1'b0;
    nxt_brk = 1'b0;
    if (ps == 2'd3) begin
      ps = 2'd2;
    end
    // Software loads while idle; writes while busy are dropped so state stays coherent
    if (wr_fire && state_ff == ST_IDLE) begin
      if (awaddr_ff == sbx_pkg::ADR_OPND) begin
        nxt_sel = wdata_ff[1:0];
        nxt_disp = wdata_ff[7:2];
        nxt_bit = wdata_ff[10:8];
        nxt_io = wdata_ff[23:16];
      end else if (awaddr_ff == sbx_pkg::ADR_PTRX) begin
        nxt_ptr[0] = wdata_ff[15:0];
      end else if (awaddr_ff == sbx_pkg::ADR_PTRY) begin
        nxt_ptr[1] = wdata_ff[15:0];
      end else if (awaddr_ff == sbx_pkg::ADR_PTRZ) begin
        nxt_ptr[2] = wdata_ff[15:0];
      end else if (awaddr_ff == sbx_pkg::ADR_REG) begin
        nxt_reg = wdata_ff[7:0];
        nxt_wpair = wdata_ff[31:16];
      end else if (awaddr_ff == sbx_pkg::ADR_SP) begin
        nxt_sp = wdata_ff[15:0];
      end else if (awaddr_ff == sbx_pkg::ADR_STAT) begin
        nxt_flag_word = wdata_ff[7:0];
        nxt_err = 1'b0;
      end else if (awaddr_ff == sbx_pkg::ADR_CMD) begin
        nxt_op = sbx_pkg::sbx_op_type'(wdata_ff[4:0]);
        nxt_cnt = op_cycles(sbx_pkg::sbx_op_type'(wdata_ff[4:0]));
        nxt_busy = 1'b1;
        nxt_state = ST_ACC;
      end
    end
    case (state_ff)
      ST_ACC: begin
        nxt_state = (cnt_ff == sbx_pkg::CYC_ONE) ? ST_IDLE : ST_FIN;
        nxt_cnt = cnt_ff - 2'd1;
        if (cnt_ff == sbx_pkg::CYC_ONE) begin
          nxt_busy = 1'b0;
        end
        case (op_ff)
          sbx_pkg::OP_ST, sbx_pkg::OP_ST_INC: begin
            nxt_mem.data_we = 1'b1;
            nxt_mem.addr = pv;
            nxt_mem.wdata = {8'h00, reg_ff};
            if (op_ff == sbx_pkg::OP_ST_INC) begin
              nxt_ptr[ps] = pv + 16'h0001;
            end
          end
          sbx_pkg::OP_ST_DEC: begin
            nxt_mem.data_we = 1'b1;
            nxt_mem.addr = pv - 16'h0001;
            nxt_mem.wdata = {8'h00, reg_ff};
            nxt_ptr[ps] = pv - 16'h0001;
          end
          sbx_pkg::OP_ST_DISP: begin
            nxt_mem.data_we = 1'b1;
            nxt_mem.addr = pv + {10'h000, disp_ff};
            nxt_mem.wdata = {8'h00, reg_ff};
          end
          sbx_pkg::OP_PM_LOAD, sbx_pkg::OP_PM_LOAD_INC: begin
            nxt_mem.prog_re = 1'b1;
            nxt_mem.addr = ptr_ff[2];
          end
          sbx_pkg::OP_PM_STORE: begin
            nxt_mem.prog_we = 1'b1;
            nxt_mem.addr = ptr_ff[2];
            nxt_mem.wdata = wpair_ff;
          end
          sbx_pkg::OP_PUSH: begin
            nxt_mem.data_we = 1'b1;
            nxt_mem.addr = sp_ff;
            nxt_mem.wdata = {8'h00, reg_ff};
            nxt_sp = sp_ff - 16'h0001;
          end
          sbx_pkg::OP_POP: begin
            nxt_sp = sp_ff + 16'h0001;
            nxt_mem.addr = sp_ff + 16'h0001;
          end
          sbx_pkg::OP_IO_SET, sbx_pkg::OP_IO_CLR: begin
            nxt_mem.addr = {8'h00, io_ff};
            if (io_ff > sbx_pkg::IO_BIT_LIMIT) begin
              nxt_err = 1'b1;
            end
          end
          sbx_pkg::OP_ROT_UP: begin
            res = {reg_ff[6:0], flag_word_ff[sbx_pkg::FLG_C]};
            nxt_reg = res;
            nxt_flag_word[sbx_pkg::FLG_C] = reg_ff[7];
            nxt_flag_word[sbx_pkg::FLG_Z] = (res == 8'h00);
            nxt_flag_word[sbx_pkg::FLG_N] = res[7];
            nxt_flag_word[sbx_pkg::FLG_V] = res[7] ^ reg_ff[7];
          end
          sbx_pkg::OP_ROT_DOWN: begin
            res = {flag_word_ff[sbx_pkg::FLG_C], reg_ff[7:1]};
            nxt_reg = res;
            nxt_flag_word[sbx_pkg::FLG_C] = reg_ff[0];
            nxt_flag_word[sbx_pkg::FLG_Z] = (res == 8'h00);
            nxt_flag_word[sbx_pkg::FLG_N] = res[7];
            nxt_flag_word[sbx_pkg::FLG_V] = res[7] ^ reg_ff[0];
          end
          sbx_pkg::OP_T_STORE: nxt_flag_word[sbx_pkg::FLG_T] = reg_ff[bit_ff];
          sbx_pkg::OP_T_LOAD: nxt_reg[bit_ff] = flag_word_ff[sbx_pkg::FLG_T];
          sbx_pkg::OP_FLAG_SET: nxt_flag_word[bit_ff] = 1'b1;
          sbx_pkg::OP_FLAG_CLR: nxt_flag_word[bit_ff] = 1'b0;
          sbx_pkg::OP_SLEEP: nxt_sleep = 1'b1;
          sbx_pkg::OP_WDOG: nxt_wdog = 1'b1;
          sbx_pkg::OP_BREAK: nxt_brk = DEBUG_EN_I;
          default: ;
        endcase
      end
      ST_FIN: begin
        nxt_cnt = cnt_ff - 2'd1;
        // Only three-cycle ops sit here with two left; keep the program address up so the
        // byte still stands on the read bus at the last cycle, without a second strobe
        if (cnt_ff == sbx_pkg::CYC_TWO) begin
          nxt_mem.addr = ptr_ff[2];
        end
        if (cnt_ff == sbx_pkg::CYC_ONE || op_cycles(op_ff) == sbx_pkg::CYC_TWO) begin
          nxt_state = ST_IDLE;
          nxt_busy = 1'b0;
          case (op_ff)
            sbx_pkg::OP_POP: nxt_reg = MEM_RDATA_I;
            sbx_pkg::OP_PM_LOAD: nxt_reg = MEM_RDATA_I;
            sbx_pkg::OP_PM_LOAD_INC: begin
              nxt_reg = MEM_RDATA_I;
              nxt_ptr[2] = ptr_ff[2] + 16'h0001;
            end
            sbx_pkg::OP_IO_SET, sbx_pkg::OP_IO_CLR: begin
              // Whole register is written back, as the I/O space expects
              if (io_ff <= sbx_pkg::IO_BIT_LIMIT) begin
                nxt_mem.io_we = 1'b1;
                nxt_mem.addr = {8'h00, io_ff};
                nxt_mem.wdata = {8'h00, MEM_RDATA_I};
                nxt_mem.wdata[bit_ff] = (op_ff == sbx_pkg::OP_IO_SET);
              end
            end
            default: ;
          endcase
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 2'd0;
      op_ff <= sbx_pkg::OP_NOP;
      flag_word_ff <= sbx_pkg::FLAG_RST;
      for (int i = 0; i < 3; i++) begin
        ptr_ff[i] <= sbx_pkg::PTR_RST;
      end
      sp_ff <= sbx_pkg::STACK_RST;
      reg_ff <= 8'h00;
      wpair_ff <= 16'h0000;
      sel_ff <= 2'd0;
      disp_ff <= 6'h00;
      bit_ff <= 3'd0;
      io_ff <= 8'h00;
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      mem_ff <= '0;
      sleep_ff <= 1'b0;
      wdog_ff <= 1'b0;
      brk_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      flag_word_ff <= nxt_flag_word;
      ptr_ff <= nxt_ptr;
      sp_ff <= nxt_sp;
      reg_ff <= nxt_reg;
      wpair_ff <= nxt_wpair;
      sel_ff <= nxt_sel;
      disp_ff <= nxt_disp;
      bit_ff <= nxt_bit;
      io_ff <= nxt_io;
      busy_ff <= nxt_busy;
      err_ff <= nxt_err;
      mem_ff <= nxt_mem;
      sleep_ff <= nxt_sleep;
      wdog_ff <= nxt_wdog;
      brk_ff <= nxt_brk;
    end
  end

  // ==========================================================================
  // Outputs
  assign S_AXI_AWREADY_O = !aw_ff && !bv_ff;
  assign S_AXI_WREADY_O = !w_ff && !bv_ff;
  assign S_AXI_BVALID_O = bv_ff;
  assign S_AXI_BRESP_O = bresp_ff;
  assign S_AXI_ARREADY_O = !rv_ff;
  assign S_AXI_RVALID_O = rv_ff;
  assign S_AXI_RDATA_O = rdata_ff;
  assign S_AXI_RRESP_O = rresp_ff;
  assign MEM_REQ_O = mem_ff;
  assign SLEEP_REQ_O = sleep_ff;
  assign WDOG_KICK_O = wdog_ff;
  assign DEBUG_BREAK_O = brk_ff;
endmodule // sbx_exec

// ---- verification/sbx_exec_assertions.sv ----
// Checker: port-level properties of the store/bit/flag execution unit
`timescale 1ns/1ps
module sbx_exec_chk (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire sbx_pkg::sbx_mem_type MEM_REQ_O,
  input wire logic SLEEP_REQ_O,
  input wire logic WDOG_KICK_O,
  input wire logic DEBUG_BREAK_O,
  input wire logic DEBUG_EN_I
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // ==========================================================================
  // Handshake steps
  sequence s_wr_both;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  // ==========================================================================
  // Bus properties
  a_write_answer: assert property (s_wr_both |-> ##[1:2] S_AXI_BVALID_O)
    else $error("write response missing");
  a_bresp_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  a_aw_blocked: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
    else $error("address taken while response pending");
  a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID_O)
    else $error("read data late");
  a_rdata_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  a_unmapped_read: assert property (s_rd_take ##0 (S_AXI_ARADDR_I > 8'h1C)
    |=> S_AXI_RRESP_O == sbx_pkg::RESP_ERR && S_AXI_RDATA_O == 32'h0000_0000)
    else $error("unmapped read not refused");
  // ==========================================================================
  // Execution properties
  a_io_range: assert property (
    MEM_REQ_O.io_we |-> MEM_REQ_O.addr <= 16'h001F) else $error("I/O write out of range");
  a_one_strobe: assert property ($onehot0({MEM_REQ_O.data_we, MEM_REQ_O.prog_re,
    MEM_REQ_O.prog_we, MEM_REQ_O.io_we, SLEEP_REQ_O, WDOG_KICK_O, DEBUG_BREAK_O}))
    else $error("two strobes at once");
  a_write_single: assert property (
    MEM_REQ_O.data_we || MEM_REQ_O.io_we |=> !MEM_REQ_O.data_we && !MEM_REQ_O.io_we)
    else $error("write strobe repeated");
  a_pulse_single: assert property (
    SLEEP_REQ_O || WDOG_KICK_O |=> !SLEEP_REQ_O && !WDOG_KICK_O)
    else $error("control pulse too long");
  a_break_gate: assert property (
    DEBUG_BREAK_O |-> $past(DEBUG_EN_I) && !$past(DEBUG_BREAK_O))
    else $error("break without debug enable");
endmodule // sbx_exec_chk

bind sbx_exec sbx_exec_chk u_chk (.REF_CLK_I, .RST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
  .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
  .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
  .S_AXI_RVALID_O, .S_AXI_RREADY_I, .MEM_REQ_O, .SLEEP_REQ_O, .WDOG_KICK_O,
  .DEBUG_BREAK_O, .DEBUG_EN_I);

// ---- verification/sbx_mem_model.sv ----
// Partner: behavioural data, stack, program and I/O byte space
`timescale 1ns/1ps
module sbx_mem_model (
  input wire logic clk_i,
  input wire sbx_pkg::sbx_mem_type req_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [256];
  // Seeded pattern so a read of a stale or wrong address shows up
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  // Answers at once; only the low address byte is decoded, so tests keep regions apart
  assign rdata_o = mem[req_i.addr[7:0]];
  always @(posedge clk_i) begin
    if (req_i.data_we || req_i.io_we) mem[req_i.addr[7:0]] <= req_i.wdata[7:0];
  end
endmodule // sbx_mem_model

// ---- verification/test_sbx_exec.sv ----
// Testbench: register-driven checks of the store/bit/flag execution unit
`timescale 1ns/1ps
module test_sbx_exec;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic arv = 1'b0, rready = 1'b0, dbg = 1'b0, ebit = 1'b0;
  logic awr, wrdy, bvalid, arr, rvalid, slp, wdk, brk;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, mrd, r, flg = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, m;
  logic [1:0] bresp, rresp, last_bresp;
  logic [15:0] p, a, np, w;
  logic [5:0] d;
  logic [2:0] b;
  logic [35:0] k;
  logic [33:0] rdq[$];
  logic [31:0] rmq[$];
  logic [35:0] mq[$];
  sbx_pkg::sbx_mem_type req;
  sbx_pkg::sbx_op_type ops[4] = '{sbx_pkg::OP_ST, sbx_pkg::OP_ST_INC, sbx_pkg::OP_ST_DEC,
    sbx_pkg::OP_ST_DISP};
  int err_count = 0;
  int total_checks = 0;

  initial forever #5 clk = ~clk;

  sbx_exec dut (.REF_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .MEM_RDATA_I(mrd), .MEM_REQ_O(req),
    .SLEEP_REQ_O(slp), .WDOG_KICK_O(wdk), .DEBUG_BREAK_O(brk), .DEBUG_EN_I(dbg));
  sbx_mem_model mdl (.clk_i(clk), .req_i(req), .rdata_o(mrd));

  // ==========================================================================
  // Bus and compare tasks
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    awaddr <= ad;
    wdata <= dt;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bvalid);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [33:0] e, input logic [31:0] mk);
    rdq.push_back(e);
    rmq.push_back(mk);
    @(posedge clk);
    araddr <= ad;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // Every op is followed by a flag-word read, so untouched flags are checked each time
  task automatic op(input sbx_pkg::sbx_op_type c, input logic [31:0] opnd);
    wr(sbx_pkg::ADR_OPND, opnd);
    wr(sbx_pkg::ADR_CMD, {27'h0, c});
    repeat (4) @(posedge clk);
    rd(sbx_pkg::ADR_STAT, {24'h0, ebit, 1'b0, flg}, 32'h0000_03FF);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Result monitor
  always @(posedge clk) begin
    if (rvalid && rready) begin
      m = rmq.pop_front();
      chk("read", 36'({rresp, rdata & m}), 36'(rdq.pop_front()));
    end
    if (|{req.data_we, req.prog_re, req.prog_we, req.io_we, slp, wdk, brk}) begin
      w = req.prog_we ? 16'hFFFF : (req.prog_re ? 16'h0000 : 16'h00FF);
      k = {req.data_we, req.prog_re, req.prog_we, req.io_we, req.addr, req.wdata & w};
      if (slp || wdk || brk) k = {17'h0, slp, wdk, brk, 16'h0000};
      chk("mem", k, mq.pop_front());
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("timeout");
    give_verdict();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(14995));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(sbx_pkg::ADR_SP, {18'h0, sbx_pkg::STACK_RST}, '1);
    rd(sbx_pkg::ADR_PTRX, 34'h0, '1);
    rd(8'h20, {2'b10, 32'h0000_0000}, '1);
    wr(8'h24, 32'h0000_0000);
    chk("bresp", 36'(last_bresp), 36'h2);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      flg[i % 8] = (i < 8);
      op(i < 8 ? sbx_pkg::OP_FLAG_SET : sbx_pkg::OP_FLAG_CLR, {21'h0, 3'(i), 8'h00});
    end
    $display("test flags done");
    b = 3'($urandom);
    mq.push_back({4'h1, 16'h001F, 8'h00, (8'h1F ^ 8'h5A) | (8'h01 << b)});
    op(sbx_pkg::OP_IO_SET, {8'h00, 8'h1F, 5'h00, b, 8'h00});
    mq.push_back({4'h1, 16'h0000, 8'h00, 8'h5A & ~(8'h01 << b)});
    op(sbx_pkg::OP_IO_CLR, {8'h00, 8'h00, 5'h00, b, 8'h00});
    ebit = 1'b1;
    op(sbx_pkg::OP_IO_SET, {8'h00, 8'h20, 5'h00, b, 8'h00});
    wr(sbx_pkg::ADR_STAT, {22'h0, 2'b10, flg});
    ebit = 1'b0;
    rd(sbx_pkg::ADR_STAT, {24'h0, 2'b00, flg}, 32'h0000_03FF);
    $display("test io bits done");
    for (int s = 0; s < 3; s++) begin
      for (int j = 0; j < 4; j++) begin
        if (j == 3 && s == 0) continue;
        p = {8'($urandom), 2'b01, 6'($urandom)};
        r = 8'($urandom);
        d = 6'($urandom);
        wr(sbx_pkg::ADR_PTRX + 8'(4 * s), {16'h0000, p});
        wr(sbx_pkg::ADR_REG, {24'h0, r});
        a = (j == 2) ? p - 16'h0001 : ((j == 3) ? p + 16'(d) : p);
        np = (j == 1) ? p + 16'h0001 : ((j == 2) ? a : p);
        mq.push_back({4'h8, a, 8'h00, r});
        op(ops[j], {24'h0, ((j == 3) ? d : 6'h00), 2'(s)});
        rd(sbx_pkg::ADR_PTRX + 8'(4 * s), {18'h0, np}, '1);
      end
    end
    $display("test stores done");
    for (int j = 0; j < 2; j++) begin
      wr(sbx_pkg::ADR_PTRZ, 32'h0000_12C3);
      mq.push_back({4'h4, 16'h12C3, 16'h0000});
      op(j ? sbx_pkg::OP_PM_LOAD_INC : sbx_pkg::OP_PM_LOAD, 32'h0000_0002);
      rd(sbx_pkg::ADR_REG, {26'h0, 8'hC3 ^ 8'h5A}, 32'h0000_00FF);
      rd(sbx_pkg::ADR_PTRZ, {18'h0, 16'h12C3 + 16'(j)}, '1);
    end
    w = 16'($urandom);
    wr(sbx_pkg::ADR_REG, {w, 16'h0000});
    mq.push_back({4'h2, 16'h12C4, w});
    op(sbx_pkg::OP_PM_STORE, 32'h0000_0002);
    $display("test program memory done");
    r = 8'($urandom);
    wr(sbx_pkg::ADR_REG, {24'h0, r});
    mq.push_back({4'h8, sbx_pkg::STACK_RST, 8'h00, r});
    op(sbx_pkg::OP_PUSH, 32'h0000_0000);
    rd(sbx_pkg::ADR_SP, {18'h0, sbx_pkg::STACK_RST - 16'h0001}, '1);
    wr(sbx_pkg::ADR_REG, 32'h0000_0000);
    op(sbx_pkg::OP_POP, 32'h0000_0000);
    rd(sbx_pkg::ADR_REG, {26'h0, r}, 32'h0000_00FF);
    rd(sbx_pkg::ADR_SP, {18'h0, sbx_pkg::STACK_RST}, '1);
    $display("test stack done");
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h80 : 8'($urandom);
      wr(sbx_pkg::ADR_REG, {24'h0, r});
      np[7:0] = i[0] ? {flg[0], r[7:1]} : {r[6:0], flg[0]};
      flg[0] = i[0] ? r[0] : r[7];
      flg[1] = (np[7:0] == 8'h00);
      flg[2] = np[7];
      flg[3] = np[7] ^ flg[0];
      op(i[0] ? sbx_pkg::OP_ROT_DOWN : sbx_pkg::OP_ROT_UP, 32'h0000_0000);
      rd(sbx_pkg::ADR_REG, {26'h0, np[7:0]}, 32'h0000_00FF);
    end
    $display("test rotates done");
    r = 8'($urandom);
    b = 3'($urandom);
    wr(sbx_pkg::ADR_REG, {24'h0, r});
    flg[6] = r[b];
    op(sbx_pkg::OP_T_STORE, {21'h0, b, 8'h00});
    b = b + 3'd3;
    r[b] = ~flg[6];
    wr(sbx_pkg::ADR_REG, {24'h0, r});
    r[b] = flg[6];
    op(sbx_pkg::OP_T_LOAD, {21'h0, b, 8'h00});
    rd(sbx_pkg::ADR_REG, {26'h0, r}, 32'h0000_00FF);
    $display("test transfer bit done");
    op(sbx_pkg::OP_NOP, 32'h0000_0000);
    mq.push_back({20'h4, 16'h0000});
    op(sbx_pkg::OP_SLEEP, 32'h0000_0000);
    mq.push_back({20'h2, 16'h0000});
    op(sbx_pkg::OP_WDOG, 32'h0000_0000);
    op(sbx_pkg::OP_BREAK, 32'h0000_0000);
    dbg <= 1'b1;
    mq.push_back({20'h1, 16'h0000});
    op(sbx_pkg::OP_BREAK, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk("pending", 36'(mq.size() + rdq.size()), 36'h0);
    $display("test control done");
    give_verdict();
  end
endmodule // test_sbx_exec
